// [crs_pkg.sv]
// Constants and types for the channel reset, strap and pin-role mux block
package crs_pkg;
  // Interface modes after strap decode
  typedef enum logic [2:0] {
    CRS_IF_SPI_SLAVE  = 3'h1,
    CRS_IF_I2C_SLAVE  = 3'h2,
    CRS_IF_SPI_MASTER = 3'h4
  } crs_iface_e;

  // Reference source select field codes
  localparam logic [1:0] CRS_REF_CRYSTAL = 2'h1;
  localparam logic [1:0] CRS_REF_EXT_CLK = 2'h2;

  // Default strap-to-mode mapping, index is {strap1, strap0}
  localparam logic [1:0] CRS_IFMAP_SPI_SLAVE  = 2'h0;
  localparam logic [1:0] CRS_IFMAP_I2C_SLAVE  = 2'h1;
  localparam logic [1:0] CRS_IFMAP_SPI_MASTER = 2'h2;

  // GPIO control layout: one bit output enable, one bit output value per pin
  localparam int CRS_GP_CTL_OE  = 0;
  localparam int CRS_GP_CTL_VAL = 1;
  localparam int CRS_GP_WIDTH   = 4;
  localparam int CRS_IC_COUNT   = 4;
  localparam int CRS_IC3_INDEX  = 2;

  // Serial master timing: SCLK half period in system cycles
  localparam int          CRS_SCLK_NS      = 160;
  localparam int          CRS_CLK_NS       = 4;
  localparam logic [7:0]  CRS_SCLK_HALF    = 8'((CRS_SCLK_NS / 2) / CRS_CLK_NS);
  localparam logic [5:0]  CRS_XFER_BITS    = 6'h20;
endpackage

// [crs_sync.sv]
// Two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ns
module crs_sync
  import crs_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      always_ff @(posedge i_clk)
      begin
        if (i_srst)
        begin
          meta_reg[b] <= 1'b0;
          o_sync[b]   <= 1'b0;
        end
        else
        begin
          meta_reg[b] <= i_async[b];
          o_sync[b]   <= meta_reg[b];
        end
      end
    end
  endgenerate
endmodule

// [crs_top.sv]
// Channel reset, boot strap capture and shared pin role mux
`timescale 1ns/1ns
// Operation
// [R1] Low channel reset holds all channel state at defaults.
// [R2] Reset release samples two config-select straps as EEPROM configuration code.
// [R3] After reset config-select pins are GPIO bits 0 and 1, first control.
// [R4] Reset release samples test strap; high enters factory test mode.
// [R5] System keeps test strap low at release for normal operation.
// [R6] After reset test strap pin is GPIO bit 2, second control.
// [R7] Reset release samples both interface-mode straps to pick interface mode.
// [R8] In SPI slave, external master drives chip select low; mode0 pin.
// [R9] In SPI master, channel asserts chip select during auto-configuration.
// [R10] In SPI master, channel drives serial clock for EEPROM accesses.
// [R11] In SPI slave, external master supplies serial clock.
// [R12] In SPI slave, channel drives read data on MISO; mode1 pin.
// [R13] In SPI master, channel captures EEPROM data on MISO.
// [R14] In I2C slave, external master supplies SCL; device never drives it.
// [R15] Reference select 01 picks crystal driver, 10 picks external clock.
// [R16] Each input clock has an enable; 0 disables it.
// [R17] Third input clock pin is GPIO bit 3 when not a clock.
// [R18] Every GPIO and serial pin driver can go high impedance.
// [R19] In SPI slave, external master sends commands and data on MOSI.
// [R20] In SPI master, channel drives commands and data on MOSI.
// [R21] Straps latch at reset release and hold until next reset.
// [R22] Strap-to-interface-mode mapping is a design parameter.
module crs_top
  import crs_pkg::*;
#(
  parameter logic [1:0] P_MAP_SPI_SLAVE  = CRS_IFMAP_SPI_SLAVE,
  parameter logic [1:0] P_MAP_I2C_SLAVE  = CRS_IFMAP_I2C_SLAVE,
  parameter logic [1:0] P_MAP_SPI_MASTER = CRS_IFMAP_SPI_MASTER
)
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_channel_reset_n,
  // Config-select / GPIO 0 and 1 pins
  input  wire logic [1:0]  i_config_select_strap,
  output logic      [1:0]  o_gp_io_low_out,
  output logic      [1:0]  o_gp_io_low_oe,
  // Test strap / GPIO 2 pin
  input  wire logic        i_gp_io_bit2,
  output logic             o_gp_io_bit2,
  output logic             o_gp_io_bit2_oe,
  // Third input clock pin / GPIO 3
  input  wire logic        i_third_input_clock_pin,
  output logic             o_gp_io_bit3,
  output logic             o_gp_io_bit3_oe,
  // GPIO control and status
  input  wire logic [3:0]  i_gp_io_control_first,
  input  wire logic [3:0]  i_gp_io_control_second,
  output logic      [3:0]  o_gp_io_state,
  // Interface mode strap 0 / chip select
  input  wire logic        i_iface_mode_strap0,
  output logic             o_chip_select_n,
  output logic             o_chip_select_n_oe,
  // Interface mode strap 1 / MISO
  input  wire logic        i_iface_mode_strap1,
  output logic             o_miso,
  output logic             o_miso_oe,
  // Serial clock pin
  input  wire logic        i_sclk,
  output logic             o_sclk,
  output logic             o_sclk_oe,
  // MOSI / SDA pin
  input  wire logic        i_mosi,
  output logic             o_mosi,
  output logic             o_mosi_oe,
  // Slave-side data path from the register engine
  input  wire logic        i_slave_read_active,
  input  wire logic        i_slave_read_bit,
  input  wire logic        i_sda_drive_low,
  // Auto-configuration request and results
  input  wire logic        i_autocfg_start,
  input  wire logic [31:0] i_autocfg_tx,
  output logic             o_autocfg_busy,
  output logic             o_autocfg_done,
  output logic      [31:0] o_autocfg_rx,
  // Reference and input clock control
  input  wire logic [1:0]  i_ref_source_select,
  input  wire logic [3:0]  i_input_clock_enable,
  output logic             o_ref_crystal_drv_en,
  output logic             o_ref_crystal_in_en,
  output logic      [3:0]  o_input_clock_gate,
  // Latched straps and channel reset status
  output logic      [1:0]  o_config_select,
  output logic             o_factory_test,
  output crs_iface_e       o_iface_mode,
  output logic             o_chan_in_reset
);
  // All pins come from outside the clock domain
  logic [10:0] pin_s;
  crs_sync #(.W(11)) u_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async ({i_channel_reset_n, i_config_select_strap, i_gp_io_bit2,
               i_third_input_clock_pin, i_iface_mode_strap0, i_iface_mode_strap1,
               i_sclk, i_mosi, 2'h0}),
    .o_sync  (pin_s)
  );
  logic       channel_reset_n_s;
  logic [1:0] acs_s;
  logic       gp2_s;
  logic       ic3_s;
  logic       if0_s;
  logic       if1_s;
  logic       sclk_s;
  logic       mosi_s;
  assign channel_reset_n_s = pin_s[10];
  assign acs_s  = pin_s[9:8];
  assign gp2_s  = pin_s[7];
  assign ic3_s  = pin_s[6];
  assign if0_s  = pin_s[5];
  assign if1_s  = pin_s[4];
  assign sclk_s = pin_s[3];
  assign mosi_s = pin_s[2];

  logic channel_reset_n_d_reg;
  logic hold;
  logic release_edge;
  assign hold         = i_srst | ~channel_reset_n_s; // [R1]
  assign release_edge = channel_reset_n_s & ~channel_reset_n_d_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      channel_reset_n_d_reg <= 1'b0;
    else
      channel_reset_n_d_reg <= channel_reset_n_s;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_chan_in_reset <= 1'b1;
    else
      o_chan_in_reset <= ~channel_reset_n_s; // [R1]
  end

  // Straps use the synchronised pin level seen with the release edge
  always_ff @(posedge i_clk)
  begin
    if (hold)
    begin
      o_config_select <= 2'h0;
      o_factory_test  <= 1'b0;
      o_iface_mode    <= CRS_IF_SPI_SLAVE;
    end
    else if (release_edge)
    begin
      o_config_select <= acs_s; // [R2] [R21]
      o_factory_test  <= gp2_s; // [R4] [R21]
      if ({if1_s, if0_s} == P_MAP_I2C_SLAVE) // [R7] [R22]
        o_iface_mode <= CRS_IF_I2C_SLAVE;
      else if ({if1_s, if0_s} == P_MAP_SPI_MASTER)
        o_iface_mode <= CRS_IF_SPI_MASTER;
      else
        o_iface_mode <= CRS_IF_SPI_SLAVE;
    end
  end

  // Straps stay frozen until the pin roles switch over
  logic run_reg;
  always_ff @(posedge i_clk)
  begin
    if (hold)
      run_reg <= 1'b0;
    else if (release_edge)
      run_reg <= 1'b1;
  end

  // GPIO drivers, off while straps are being sampled
  logic ic3_is_gpio;
  assign ic3_is_gpio = ~i_input_clock_enable[CRS_IC3_INDEX];

  always_ff @(posedge i_clk)
  begin
    if (hold)
    begin
      o_gp_io_low_out <= 2'h0;
      o_gp_io_low_oe  <= 2'h0;
      o_gp_io_bit2    <= 1'b0;
      o_gp_io_bit2_oe <= 1'b0;
      o_gp_io_bit3    <= 1'b0;
      o_gp_io_bit3_oe <= 1'b0;
    end
    else
    begin
      o_gp_io_low_out <= {i_gp_io_control_first[2 + CRS_GP_CTL_VAL],
                          i_gp_io_control_first[CRS_GP_CTL_VAL]}; // [R3]
      o_gp_io_low_oe  <= {i_gp_io_control_first[2 + CRS_GP_CTL_OE],
                          i_gp_io_control_first[CRS_GP_CTL_OE]} & {2{run_reg}}; // [R18]
      o_gp_io_bit2    <= i_gp_io_control_second[CRS_GP_CTL_VAL]; // [R6]
      o_gp_io_bit2_oe <= i_gp_io_control_second[CRS_GP_CTL_OE] & run_reg; // [R18]
      o_gp_io_bit3    <= i_gp_io_control_second[2 + CRS_GP_CTL_VAL]; // [R17]
      o_gp_io_bit3_oe <= i_gp_io_control_second[2 + CRS_GP_CTL_OE] & run_reg
                         & ic3_is_gpio; // [R17] [R18]
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (hold)
      o_gp_io_state <= 4'h0;
    else
      o_gp_io_state <= {ic3_s, gp2_s, acs_s}; // [R3] [R6] [R17]
  end

  // Reference and input clock gating
  always_ff @(posedge i_clk)
  begin
    if (hold)
    begin
      o_ref_crystal_drv_en <= 1'b0;
      o_ref_crystal_in_en  <= 1'b0;
      o_input_clock_gate   <= 4'h0;
    end
    else
    begin
      o_ref_crystal_drv_en <= (i_ref_source_select == CRS_REF_CRYSTAL); // [R15]
      o_ref_crystal_in_en  <= (i_ref_source_select == CRS_REF_EXT_CLK); // [R15]
      o_input_clock_gate   <= i_input_clock_enable; // [R16]
    end
  end

  // SPI master engine for EEPROM auto-configuration
  logic        is_master;
  logic [7:0]  div_reg;
  logic [5:0]  bit_reg;
  logic [31:0] tx_reg;
  logic        sclk_q_reg;
  assign is_master = run_reg & (o_iface_mode == CRS_IF_SPI_MASTER);

  always_ff @(posedge i_clk)
  begin
    if (hold)
    begin
      o_autocfg_busy  <= 1'b0;
      o_autocfg_done  <= 1'b0;
      o_autocfg_rx    <= 32'h0;
      div_reg         <= 8'h0;
      bit_reg         <= 6'h0;
      tx_reg          <= 32'h0;
      sclk_q_reg      <= 1'b0;
    end
    else if (!o_autocfg_busy)
    begin
      o_autocfg_done <= 1'b0;
      sclk_q_reg     <= 1'b0;
      if (i_autocfg_start && is_master)
      begin
        o_autocfg_busy <= 1'b1; // [R9]
        tx_reg         <= i_autocfg_tx;
        bit_reg        <= CRS_XFER_BITS;
        div_reg        <= CRS_SCLK_HALF;
      end
    end
    else if (div_reg > 8'h1)
      div_reg <= div_reg - 8'h1;
    else
    begin
      div_reg    <= CRS_SCLK_HALF;
      sclk_q_reg <= ~sclk_q_reg; // [R10]
      if (!sclk_q_reg)
        o_autocfg_rx <= {o_autocfg_rx[30:0], if1_s}; // [R13]
      else
      begin
        tx_reg  <= {tx_reg[30:0], 1'b0}; // [R20]
        bit_reg <= bit_reg - 6'h1;
        if (bit_reg == 6'h1)
        begin
          o_autocfg_busy <= 1'b0;
          o_autocfg_done <= 1'b1;
        end
      end
    end
  end

  // Pin role drivers; slave input if0_s gates MISO, while sclk_s and mosi_s drive no port
  logic is_spi_slave;
  logic is_i2c;
  assign is_spi_slave = run_reg & (o_iface_mode == CRS_IF_SPI_SLAVE);
  assign is_i2c       = run_reg & (o_iface_mode == CRS_IF_I2C_SLAVE);

  always_ff @(posedge i_clk)
  begin
    if (hold)
    begin
      o_chip_select_n    <= 1'b1;
      o_chip_select_n_oe <= 1'b0;
      o_sclk             <= 1'b0;
      o_sclk_oe          <= 1'b0;
      o_mosi             <= 1'b0;
      o_mosi_oe          <= 1'b0;
      o_miso             <= 1'b0;
      o_miso_oe          <= 1'b0;
    end
    else
    begin
      o_chip_select_n    <= ~o_autocfg_busy; // [R9]
      o_chip_select_n_oe <= is_master; // [R8] [R18]
      o_sclk             <= sclk_q_reg; // [R10]
      o_sclk_oe          <= is_master; // [R11] [R14]
      o_mosi             <= is_master & tx_reg[31]; // [R20]
      o_mosi_oe          <= is_master | (is_i2c & i_sda_drive_low); // [R19]
      o_miso             <= i_slave_read_bit; // [R12]
      o_miso_oe          <= is_spi_slave & i_slave_read_active & ~if0_s; // [R12]
    end
  end
endmodule

// [crs_top_asserts.sv]
// Concurrent checks on the reset, strap and pin-role mux ports
`timescale 1ns/1ns
module crs_top_asserts
  import crs_pkg::*;
(
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_srst,
  // Observed ports
  input wire logic [1:0] i_ref_source_select,
  input wire logic [3:0] i_input_clock_enable,
  input wire logic [1:0] o_gp_io_low_oe,
  input wire logic       o_gp_io_bit2_oe,
  input wire logic       o_gp_io_bit3_oe,
  input wire logic       o_chip_select_n,
  input wire logic       o_sclk_oe,
  input wire logic       o_ref_crystal_drv_en,
  input wire logic       o_autocfg_busy,
  input wire logic       o_autocfg_done,
  input wire logic [1:0] o_config_select,
  input wire logic       o_factory_test,
  input wire crs_iface_e o_iface_mode,
  input wire logic       o_chan_in_reset
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence run3;
    !o_chan_in_reset [*3];
  endsequence
  sequence xfer_go;
    $rose(o_autocfg_busy);
  endsequence
  // A whole transfer is too long for a delay range, so count busy cycles instead
  localparam int XFER_CYC = 2 * CRS_XFER_BITS * CRS_SCLK_HALF;
  logic [10:0] busy_cyc;
  always_ff @(posedge i_clk)
  begin
    if (i_srst || !o_autocfg_busy)
      busy_cyc <= 11'h0;
    else
      busy_cyc <= busy_cyc + 11'h1;
  end
  // Second cycle of hold so the registered drivers have settled
  reset_quiet_a: assert property (o_chan_in_reset && $past(o_chan_in_reset)
    |-> o_gp_io_low_oe == 2'h0 && !o_gp_io_bit2_oe && !o_gp_io_bit3_oe && o_chip_select_n)
    else $error("pin driven during channel reset");
  strap_hold_a: assert property (run3 |-> $stable(o_config_select)
    && $stable(o_iface_mode) && $stable(o_factory_test))
    else $error("latched strap moved while running");
  xtal_sel_a: assert property (!o_chan_in_reset && !$past(o_chan_in_reset)
    |-> o_ref_crystal_drv_en == ($past(i_ref_source_select) == CRS_REF_CRYSTAL))
    else $error("crystal driver enable mismatch");
  cs_assert_a: assert property (xfer_go |=> !o_chip_select_n)
    else $error("chip select not asserted");
  xfer_len_a: assert property (o_autocfg_done |-> busy_cyc == 11'(XFER_CYC))
    else $error("transfer length wrong");
  done_end_a: assert property (o_autocfg_done |-> !o_autocfg_busy ##1 o_chip_select_n)
    else $error("transfer end sequence wrong");
  sclk_drive_a: assert property (o_autocfg_busy && !o_chip_select_n |-> o_sclk_oe)
    else $error("serial clock not driven");
  scl_free_a: assert property (o_iface_mode == CRS_IF_I2C_SLAVE |-> !o_sclk_oe)
    else $error("clock driven in two-wire mode");
  ic3_gpio_a: assert property ($past(i_input_clock_enable[2]) |-> !o_gp_io_bit3_oe)
    else $error("third clock pin driven while enabled");
endmodule

// [crs_eeprom_model.sv]
// Serial EEPROM model answering the channel's auto-configuration transfer
`timescale 1ns/1ns
module crs_eeprom_model #(
  parameter logic [31:0] P_WORD = 32'hC3A5_5A3C
)
(
  // Serial pins
  input  wire logic        i_cs_n,
  input  wire logic        i_sclk,
  input  wire logic        i_mosi,
  output logic             o_miso,
  // Word received from the channel
  output logic      [31:0] o_rx
);
  logic [31:0] sh_reg;
  initial o_miso = 1'b0;
  // Released line flips so a stale bit can never pass for data
  always @(posedge i_cs_n) o_miso <= ~o_miso;
  always @(negedge i_cs_n)
  begin
    sh_reg <= P_WORD;
    o_miso <= P_WORD[31];
  end
  always @(negedge i_sclk)
  begin
    if (!i_cs_n)
    begin
      sh_reg <= sh_reg << 1;
      o_miso <= sh_reg[30];
    end
  end
  always @(posedge i_sclk)
  begin
    if (!i_cs_n)
      o_rx <= {o_rx[30:0], i_mosi};
  end
endmodule

// [tb_top.sv]
// Self-checking bench for the channel reset, strap and pin-role mux
`timescale 1ns/1ns
module tb_top;
  import crs_pkg::*;
  localparam logic [31:0] EE_WORD = 32'h5AC3_3CA5;
  logic        i_clk, i_srst, i_channel_reset_n, i_gp_io_bit2, i_third_input_clock_pin;
  logic        i_slave_read_active, i_slave_read_bit, i_sda_drive_low, i_autocfg_start;
  logic        o_gp_io_bit2, o_gp_io_bit2_oe, o_gp_io_bit3, o_gp_io_bit3_oe, o_chip_select_n;
  logic        o_chip_select_n_oe, o_miso, o_miso_oe, o_sclk, o_sclk_oe, o_mosi, o_mosi_oe;
  logic        o_autocfg_busy, o_autocfg_done, o_ref_crystal_drv_en, o_ref_crystal_in_en;
  logic        o_factory_test, o_chan_in_reset, s0, s1, ee_miso;
  logic [1:0]  i_config_select_strap, o_gp_io_low_out, o_gp_io_low_oe, i_ref_source_select;
  logic [1:0]  o_config_select;
  logic [3:0]  i_gp_io_control_first, i_gp_io_control_second, o_gp_io_state;
  logic [3:0]  i_input_clock_enable, o_input_clock_gate;
  logic [31:0] i_autocfg_tx, o_autocfg_rx, ee_rx;
  crs_iface_e  o_iface_mode;
  int          err_total = 0, checks = 0, cyc = 0;
  // Shared pins: the channel's driver wins whenever its enable is high
  wire logic   i_iface_mode_strap0 = o_chip_select_n_oe ? o_chip_select_n : s0;
  // Strap resistor sets the level unless the channel drives MISO or runs the memory as master
  wire logic   i_iface_mode_strap1 = o_miso_oe ? o_miso : (o_chip_select_n_oe ? ee_miso : s1);
  wire logic   i_sclk = o_sclk_oe ? o_sclk : 1'b0;
  wire logic   i_mosi = o_mosi_oe ? o_mosi : 1'b1;

  crs_top crs_top_i (.*);
  crs_eeprom_model #(.P_WORD(EE_WORD)) crs_eeprom_model_i (.i_cs_n(i_iface_mode_strap0),
    .i_sclk(i_sclk), .i_mosi(i_mosi), .o_miso(ee_miso), .o_rx(ee_rx));

  always #2 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total = err_total + 1;
      end_sim();
    end
  end

  task automatic end_sim;
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks = checks + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Pulse channel reset with given straps, then scramble the pins
  task automatic boot(input logic [1:0] ac, input logic t, input logic [1:0] ifm);
    @(posedge i_clk);
    i_channel_reset_n <= 1'b0;
    i_config_select_strap <= ac;
    i_gp_io_bit2 <= t;
    s0 <= ifm[0];
    s1 <= ifm[1];
    tick(6);
    @(negedge i_clk);
    chk("in_reset", 1, o_chan_in_reset);
    tick(1);
    i_channel_reset_n <= 1'b1;
    tick(8);
    i_config_select_strap <= ~ac;
    i_gp_io_bit2 <= 1'b0;
    s0 <= 1'b1;
    s1 <= ~ifm[1];
    tick(8);
    @(negedge i_clk);
    chk("cfg", ac, o_config_select);
    chk("test", t, o_factory_test);
  endtask
  task automatic strap_modes;
    crs_iface_e want [4] = '{CRS_IF_SPI_SLAVE, CRS_IF_I2C_SLAVE, CRS_IF_SPI_MASTER,
      CRS_IF_SPI_SLAVE};
    for (int m = 0; m < 4; m++)
    begin
      boot(2'(m), m[0], 2'(m));
      chk("mode", want[m], o_iface_mode);
    end
  endtask
  task automatic gpio_roles;
    boot(2'h1, 1'b0, 2'h0);
    tick(4);
    @(negedge i_clk);
    chk("state", 4'hA, o_gp_io_state);
    tick(1);
    i_gp_io_control_first <= 4'h7;
    i_gp_io_control_second <= 4'hD;
    i_input_clock_enable <= 4'h4;
    tick(4);
    @(negedge i_clk);
    chk("low", 4'hD, {o_gp_io_low_oe, o_gp_io_low_out});
    chk("bit2", 2'h2, {o_gp_io_bit2_oe, o_gp_io_bit2});
    chk("bit3_oe", 0, o_gp_io_bit3_oe);
    tick(1);
    i_input_clock_enable <= 4'h0;
    tick(4);
    @(negedge i_clk);
    chk("bit3", 2'h3, {o_gp_io_bit3_oe, o_gp_io_bit3});
  endtask
  task automatic ref_select;
    for (int s = 0; s < 4; s++)
    begin
      tick(1);
      i_ref_source_select <= 2'(s);
      i_input_clock_enable <= 4'(1 << s);
      tick(3);
      @(negedge i_clk);
      chk("xtal", s == 1, o_ref_crystal_drv_en);
      chk("xa", s == 2, o_ref_crystal_in_en);
      chk("gate", 1 << s, o_input_clock_gate);
    end
  endtask
  task automatic master_xfer;
    boot(2'h2, 1'b0, 2'h2);
    tick(1);
    i_autocfg_tx <= 32'h96E1_0F3C;
    i_autocfg_start <= 1'b1;
    tick(1);
    i_autocfg_start <= 1'b0;
    for (int n = 0; n < 1500 && o_autocfg_done !== 1'b1; n++) @(negedge i_clk);
    chk("done", 1, o_autocfg_done);
    chk("rx", EE_WORD, o_autocfg_rx);
    chk("ee_rx", 32'h96E1_0F3C, ee_rx);
  endtask
  task automatic slave_pins;
    boot(2'h0, 1'b0, 2'h0);
    tick(1);
    s0 <= 1'b0;
    i_slave_read_active <= 1'b1;
    i_slave_read_bit <= 1'b1;
    i_autocfg_start <= 1'b1;
    tick(1);
    i_autocfg_start <= 1'b0;
    tick(5);
    @(negedge i_clk);
    chk("miso", 2'h3, {o_miso_oe, o_miso});
    chk("busy", 0, o_autocfg_busy);
    tick(1);
    s0 <= 1'b1;
    tick(5);
    @(negedge i_clk);
    chk("miso_oe", 0, o_miso_oe);
    boot(2'h0, 1'b0, 2'h1);
    tick(1);
    i_sda_drive_low <= 1'b1;
    tick(4);
    @(negedge i_clk);
    chk("sda", 2'h2, {o_mosi_oe, o_mosi});
  endtask

  initial
  begin
    {i_clk, i_channel_reset_n, i_gp_io_bit2, s0, s1, i_slave_read_active} = '0;
    {i_slave_read_bit, i_sda_drive_low, i_autocfg_start, i_config_select_strap} = '0;
    {i_gp_io_control_first, i_gp_io_control_second, i_input_clock_enable} = '0;
    {i_ref_source_select, i_autocfg_tx} = '0;
    i_third_input_clock_pin = 1'b1;
    i_srst = 1'b1;
    tick(10);
    i_srst <= 1'b0;
    strap_modes();
    gpio_roles();
    ref_select();
    master_xfer();
    slave_pins();
    end_sim();
  end
endmodule

bind crs_top crs_top_asserts crs_top_asserts_i (.*);
